// ### rtl/sbh_pkg.sv
package sbh_pkg;
  // input types
  typedef enum logic [3:0] {
    SBH_IN_TC_J   = 4'h0,
    SBH_IN_TC_K   = 4'h1,
    SBH_IN_PT100  = 4'h2,
    SBH_IN_LINEAR = 4'h3,
    SBH_IN_COMMS  = 4'h4
  } sbh_in_type_e;

  typedef enum logic [1:0] {
    SBH_SB_OFF = 2'h0,
    SBH_SB_ON  = 2'h1,
    SBH_SB_LAT = 2'h2
  } sbh_sb_mode_e;

  typedef enum logic [1:0] {
    SBH_OUT_HEAT_COOL = 2'h0,
    SBH_OUT_HEAT_ONLY = 2'h1,
    SBH_OUT_COOL_ONLY = 2'h2
  } sbh_out_type_e;

  // alarm state, gray along idle -> active -> latched
  typedef enum logic [1:0] {
    SBH_AL_IDLE   = 2'b00,
    SBH_AL_ACTIVE = 2'b01,
    SBH_AL_LATCH  = 2'b11
  } sbh_alarm_e;

  // percent in tenths, signed 16 bit
  localparam logic signed [15:0] SBH_PCT_FULL = 16'sh03E8;
  localparam logic signed [15:0] SBH_PCT_ZERO = 16'sh0000;
  localparam logic signed [15:0] SBH_PCT_MFULL = -16'sh03E8;

  // temperature ranges in degrees C
  localparam logic signed [15:0] SBH_J_MIN  = -16'sh00D2;
  localparam logic signed [15:0] SBH_J_MAX  = 16'sh04B0;
  localparam logic signed [15:0] SBH_K_MIN  = -16'sh00C8;
  localparam logic signed [15:0] SBH_K_MAX  = 16'sh055C;
  localparam logic signed [15:0] SBH_PT_MIN = -16'sh00C8;
  localparam logic signed [15:0] SBH_PT_MAX = 16'sh0352;
  // millivolts in hundredths
  localparam logic signed [15:0] SBH_MV_MIN = -16'sh03E8;
  localparam logic signed [15:0] SBH_MV_MAX = 16'sh1F40;
  localparam logic signed [15:0] SBH_MV_LO_RST = -16'sh03E8;
  localparam logic signed [15:0] SBH_MV_HI_RST = 16'sh1F40;
  // linear break margin, percent of setting
  localparam int SBH_LIN_MARGIN_PCT = 5;

  // filter time in tenths of seconds; 0 means off
  localparam logic [15:0] SBH_FILT_RST = 16'h000F;
  localparam logic [15:0] SBH_OFS_RST  = 16'h0000;
  localparam logic signed [15:0] SBH_SAFE_RST = 16'sh0000;

  localparam int SBH_CLK_HZ       = 200_000_000;
  localparam int SBH_COMMS_TMO_S  = 5;
  localparam longint SBH_COMMS_TMO_CYC = longint'(SBH_COMMS_TMO_S) * longint'(SBH_CLK_HZ);
  // filter sample tick, 0.1 s
  localparam int SBH_TICK_MS  = 100;
  localparam longint SBH_TICK_CYC = longint'(SBH_TICK_MS) * longint'(SBH_CLK_HZ) / 1000;
  localparam int SBH_COMMS_ADDR = 203;

  localparam logic [7:0] SBH_REG_SB_MODE  = 8'h00;
  localparam logic [7:0] SBH_REG_OUT_TYPE = 8'h04;
  localparam logic [7:0] SBH_REG_OUT_HI   = 8'h08;
  localparam logic [7:0] SBH_REG_OUT_LO   = 8'h0C;
  localparam logic [7:0] SBH_REG_SAFE     = 8'h10;
  localparam logic [7:0] SBH_REG_IN_TYPE  = 8'h14;
  localparam logic [7:0] SBH_REG_OFFSET   = 8'h18;
  localparam logic [7:0] SBH_REG_FILT     = 8'h1C;
  localparam logic [7:0] SBH_REG_MV_LO    = 8'h20;
  localparam logic [7:0] SBH_REG_MV_HI    = 8'h24;
  localparam logic [7:0] SBH_REG_COMMS    = 8'h28;
  localparam logic [7:0] SBH_REG_ACK      = 8'h2C;
  localparam logic [7:0] SBH_REG_STATUS   = 8'h30;
  localparam logic [7:0] SBH_REG_PV       = 8'h34;
  localparam logic [7:0] SBH_REG_RATE     = 8'h38;
  localparam logic [7:0] SBH_REG_MV       = 8'h3C;
  localparam logic [7:0] SBH_REG_CTRL_OUT = 8'h40;
endpackage : sbh_pkg

// ### rtl/sbh_rate_filter.sv
`timescale 1ns/1ps
// first-order filter on pv difference per tick
module sbh_rate_filter (
  input  wire logic               clk,          // clock
  input  wire logic               rst_b,        // async reset, active low
  input  wire logic               tick,         // sample strobe
  input  wire logic signed [15:0] pv,           // process value
  input  wire logic        [15:0] filt_time,    // tenths of s, 0 off
  output logic signed [15:0]      rate          // filtered rate
);
  logic signed [15:0] pv_prev;
  logic signed [15:0] next_pv_prev;
  logic signed [15:0] next_rate;
  logic signed [31:0] raw;
  logic signed [31:0] step;

  always_comb begin
    raw          = 32'(pv) - 32'(pv_prev);
    step         = 32'sh0;
    next_pv_prev = pv_prev;
    next_rate    = rate;
    if (tick) begin
      next_pv_prev = pv;
      if (filt_time == 16'h0000) begin
        next_rate = raw[15:0];
      end else begin
        // step by 1/(tau/dt); dt is one tick in tenths
        step      = (raw - 32'(rate)) / $signed({16'h0000, filt_time});
        next_rate = 16'(32'(rate) + step);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pv_prev <= 16'sh0000;
      rate    <= 16'sh0000;
    end else begin
      pv_prev <= next_pv_prev;
      rate    <= next_rate;
    end
  end
endmodule : sbh_rate_filter

// ### rtl/sbh_top.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module sbh_top #(
  parameter longint COMMS_TMO_CYC = sbh_pkg::SBH_COMMS_TMO_CYC, // comms timeout
  parameter longint TICK_CYC      = sbh_pkg::SBH_TICK_CYC       // filter tick period
) (
  input  wire logic               clk,           // clock 200 MHz
  input  wire logic               rst_b,         // async reset, active low
  input  wire logic        [7:0]  addr,          // register byte address
  input  wire logic        [31:0] wdata,         // write data
  input  wire logic               wr,            // write strobe
  input  wire logic               rd,            // read strobe
  output logic             [31:0] rdata,         // read data, cycle after rd
  input  wire logic               open_circuit,  // front-end break flag, level
  input  wire logic signed [15:0] meas_value,    // linearised measurement
  input  wire logic signed [15:0] millivolt_in,  // raw terminal mV, hundredths
  input  wire logic signed [15:0] ctrl_demand,   // normal control demand
  output logic signed [15:0]      ctrl_out,      // control output
  output logic                    alarm_beacon,  // beacon flashing enable
  output logic                    alarm_relay,   // alarm output relay
  output logic                    sensor_break   // break in effect
);
  sbh_pkg::sbh_sb_mode_e  sensor_break_mode, next_mode;
  sbh_pkg::sbh_out_type_e out_type, next_out_type;
  sbh_pkg::sbh_in_type_e  in_type, next_in_type;
  sbh_pkg::sbh_alarm_e    al_state, next_al_state;
  logic signed [15:0] output_upper_limit, next_hi;
  logic signed [15:0] output_lower_limit, next_lo;
  logic signed [15:0] safe_value, next_safe;
  logic signed [15:0] process_value_offset, next_ofs;
  logic        [15:0] rate_filter_time, next_filt;
  logic signed [15:0] mv_lo, next_mv_lo;
  logic signed [15:0] mv_hi, next_mv_hi;
  logic signed [15:0] comms_value, next_comms;
  logic        [39:0] tmo_cnt, next_tmo_cnt;
  logic        [31:0] tick_cnt, next_tick_cnt;
  logic               tick;
  logic signed [15:0] pv, next_pv;
  logic signed [15:0] millivolt_reading, next_mvr;
  logic signed [15:0] rate_of_change_value;
  logic signed [15:0] next_ctrl_out;
  logic               next_beacon, next_relay, brk, next_brk;
  logic        [31:0] next_rdata;
  logic signed [15:0] lim_min, lim_max, span_min, span_max;
  logic signed [31:0] sel, mlo, mhi;
  logic               wr_ack;

  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  function automatic logic hit(input logic [7:0] a);
    hit = wr && (addr == a);
  endfunction : hit

  // limit ranges from output type, span ranges from input type
  always_comb begin
    case (out_type)
      sbh_pkg::SBH_OUT_HEAT_ONLY: begin
        lim_min = sbh_pkg::SBH_PCT_ZERO;
        lim_max = sbh_pkg::SBH_PCT_FULL;
      end
      sbh_pkg::SBH_OUT_COOL_ONLY: begin
        lim_min = sbh_pkg::SBH_PCT_MFULL;
        lim_max = sbh_pkg::SBH_PCT_ZERO;
      end
      default: begin
        lim_min = sbh_pkg::SBH_PCT_MFULL;
        lim_max = sbh_pkg::SBH_PCT_FULL;
      end
    endcase
    case (in_type)
      sbh_pkg::SBH_IN_TC_J: begin
        span_min = sbh_pkg::SBH_J_MIN;
        span_max = sbh_pkg::SBH_J_MAX;
      end
      sbh_pkg::SBH_IN_TC_K: begin
        span_min = sbh_pkg::SBH_K_MIN;
        span_max = sbh_pkg::SBH_K_MAX;
      end
      sbh_pkg::SBH_IN_PT100: begin
        span_min = sbh_pkg::SBH_PT_MIN;
        span_max = sbh_pkg::SBH_PT_MAX;
      end
      default: begin
        span_min = 16'sh8000;
        span_max = 16'sh7FFF;
      end
    endcase
  end

  // configuration writes
  always_comb begin
    next_mode     = sensor_break_mode;
    next_out_type = out_type;
    next_in_type  = in_type;
    next_hi       = output_upper_limit;
    next_lo       = output_lower_limit;
    next_safe     = safe_value;
    next_ofs      = process_value_offset;
    next_filt     = rate_filter_time;
    next_mv_lo    = mv_lo;
    next_mv_hi    = mv_hi;
    next_comms    = comms_value;
    wr_ack        = hit(sbh_pkg::SBH_REG_ACK) && wdata[0];
    if (hit(sbh_pkg::SBH_REG_SB_MODE) && (wdata[1:0] != 2'h3)) begin
      next_mode = sbh_pkg::sbh_sb_mode_e'(wdata[1:0]);
    end
    if (hit(sbh_pkg::SBH_REG_OUT_TYPE) && (wdata[1:0] != 2'h3)) begin
      next_out_type = sbh_pkg::sbh_out_type_e'(wdata[1:0]);
    end
    if (hit(sbh_pkg::SBH_REG_IN_TYPE) && (wdata[3:0] <= 4'h4)) begin
      next_in_type = sbh_pkg::sbh_in_type_e'(wdata[3:0]);
    end
    if (hit(sbh_pkg::SBH_REG_OUT_HI)) begin
      next_hi = wdata[15:0];
    end
    if (hit(sbh_pkg::SBH_REG_OUT_LO)) begin
      next_lo = wdata[15:0];
    end
    if (hit(sbh_pkg::SBH_REG_SAFE)) begin
      next_safe = wdata[15:0];
    end
    if (hit(sbh_pkg::SBH_REG_OFFSET)) begin
      next_ofs = wdata[15:0];
    end
    if (hit(sbh_pkg::SBH_REG_FILT)) begin
      next_filt = wdata[15:0];
    end
    if (hit(sbh_pkg::SBH_REG_MV_LO)) begin
      next_mv_lo = clamp(wdata[15:0], sbh_pkg::SBH_MV_MIN, sbh_pkg::SBH_MV_MAX);
    end
    if (hit(sbh_pkg::SBH_REG_MV_HI)) begin
      next_mv_hi = clamp(wdata[15:0], sbh_pkg::SBH_MV_MIN, sbh_pkg::SBH_MV_MAX);
    end
    if (hit(sbh_pkg::SBH_REG_COMMS)) begin
      next_comms = wdata[15:0];
    end
    // limits always re-clamped so a type change also pulls them in
    next_hi = clamp(next_hi, lim_min, lim_max);
    next_lo = clamp(next_lo, lim_min, next_hi);
    // safe follows whichever limit it now violates
    if (next_safe < next_lo) begin
      next_safe = next_lo;
    end else if (next_safe > next_hi) begin
      next_safe = next_hi;
    end
  end

  // process value, timeout, break detection
  always_comb begin
    next_tick_cnt = (tick_cnt >= 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt + 32'h1;
    next_tmo_cnt  = tmo_cnt;
    if (in_type != sbh_pkg::SBH_IN_COMMS || hit(sbh_pkg::SBH_REG_COMMS)) begin
      next_tmo_cnt = 40'h0;
    end else if (tmo_cnt < 40'(COMMS_TMO_CYC)) begin
      next_tmo_cnt = tmo_cnt + 40'h1;
    end
    sel = (in_type == sbh_pkg::SBH_IN_COMMS) ? 32'(comms_value) : 32'(clamp(meas_value, span_min, span_max));
    next_pv  = clamp(16'(sel + 32'(process_value_offset)), 16'sh8000, 16'sh7FFF);
    next_mvr = millivolt_in;
    mlo = 32'(mv_lo) - (32'(mv_lo < 0 ? -mv_lo : mv_lo) * sbh_pkg::SBH_LIN_MARGIN_PCT) / 100;
    mhi = 32'(mv_hi) + (32'(mv_hi < 0 ? -mv_hi : mv_hi) * sbh_pkg::SBH_LIN_MARGIN_PCT) / 100;
    next_brk = open_circuit;
    if (in_type == sbh_pkg::SBH_IN_LINEAR && (32'(millivolt_in) < mlo || 32'(millivolt_in) > mhi)) begin
      next_brk = 1'b1;
    end
    if (in_type == sbh_pkg::SBH_IN_COMMS && tmo_cnt >= 40'(COMMS_TMO_CYC)) begin
      next_brk = 1'b1;
    end
  end

  // alarm state and output choice
  always_comb begin
    next_al_state = al_state;
    case (al_state)
      sbh_pkg::SBH_AL_IDLE: begin
        if (brk && sensor_break_mode != sbh_pkg::SBH_SB_OFF) begin
          next_al_state = sbh_pkg::SBH_AL_ACTIVE;
        end
      end
      sbh_pkg::SBH_AL_ACTIVE: begin
        // acknowledge ignored here while break persists
        if (sensor_break_mode == sbh_pkg::SBH_SB_OFF) begin
          next_al_state = sbh_pkg::SBH_AL_IDLE;
        end else if (!brk && sensor_break_mode == sbh_pkg::SBH_SB_ON) begin
          next_al_state = sbh_pkg::SBH_AL_IDLE;
        end else if (!brk) begin
          next_al_state = sbh_pkg::SBH_AL_LATCH;
        end
      end
      sbh_pkg::SBH_AL_LATCH: begin
        if (brk) begin
          next_al_state = sbh_pkg::SBH_AL_ACTIVE;
        end else if (wr_ack || sensor_break_mode != sbh_pkg::SBH_SB_LAT) begin
          next_al_state = sbh_pkg::SBH_AL_IDLE;
        end
      end
      default: begin
        next_al_state = sbh_pkg::SBH_AL_IDLE;
      end
    endcase
    next_beacon = (next_al_state != sbh_pkg::SBH_AL_IDLE);
    next_relay  = next_beacon;
    next_ctrl_out = clamp(ctrl_demand, output_lower_limit, output_upper_limit);
    if (brk) begin
      if (sensor_break_mode == sbh_pkg::SBH_SB_OFF) begin
        next_ctrl_out = output_upper_limit;
      end else if (safe_value >= output_lower_limit && safe_value <= output_upper_limit) begin
        next_ctrl_out = safe_value;
      end else begin
        next_ctrl_out = output_upper_limit;
      end
    end
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0;
    if (rd) begin
      case (addr)
        sbh_pkg::SBH_REG_SB_MODE:  next_rdata = {30'h0, sensor_break_mode};
        sbh_pkg::SBH_REG_OUT_TYPE: next_rdata = {30'h0, out_type};
        sbh_pkg::SBH_REG_OUT_HI:   next_rdata = {16'h0, output_upper_limit};
        sbh_pkg::SBH_REG_OUT_LO:   next_rdata = {16'h0, output_lower_limit};
        sbh_pkg::SBH_REG_SAFE:     next_rdata = {16'h0, safe_value};
        sbh_pkg::SBH_REG_IN_TYPE:  next_rdata = {28'h0, in_type};
        sbh_pkg::SBH_REG_OFFSET:   next_rdata = {16'h0, process_value_offset};
        sbh_pkg::SBH_REG_FILT:     next_rdata = {16'h0, rate_filter_time};
        sbh_pkg::SBH_REG_MV_LO:    next_rdata = {16'h0, mv_lo};
        sbh_pkg::SBH_REG_MV_HI:    next_rdata = {16'h0, mv_hi};
        sbh_pkg::SBH_REG_COMMS:    next_rdata = {16'h0, comms_value};
        sbh_pkg::SBH_REG_STATUS:   next_rdata = {28'h0, al_state, alarm_relay, brk};
        sbh_pkg::SBH_REG_PV:       next_rdata = {16'h0, pv};
        sbh_pkg::SBH_REG_RATE:     next_rdata = {16'h0, rate_of_change_value};
        sbh_pkg::SBH_REG_MV:       next_rdata = {16'h0, millivolt_reading};
        sbh_pkg::SBH_REG_CTRL_OUT: next_rdata = {16'h0, ctrl_out};
        default:                   next_rdata = 32'h0;
      endcase
    end
  end

  assign tick = (tick_cnt == 32'h0);

  sbh_rate_filter i_sbh_rate_filter (
    .clk       (clk),
    .rst_b     (rst_b),
    .tick      (tick),
    .pv        (pv),
    .filt_time (rate_filter_time),
    .rate      (rate_of_change_value)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sensor_break_mode    <= sbh_pkg::SBH_SB_ON;
      out_type             <= sbh_pkg::SBH_OUT_HEAT_COOL;
      in_type              <= sbh_pkg::SBH_IN_TC_K;
      al_state             <= sbh_pkg::SBH_AL_IDLE;
      output_upper_limit   <= sbh_pkg::SBH_PCT_FULL;
      output_lower_limit   <= sbh_pkg::SBH_PCT_MFULL;
      safe_value           <= sbh_pkg::SBH_SAFE_RST;
      process_value_offset <= sbh_pkg::SBH_OFS_RST;
      rate_filter_time     <= sbh_pkg::SBH_FILT_RST;
      mv_lo                <= sbh_pkg::SBH_MV_LO_RST;
      mv_hi                <= sbh_pkg::SBH_MV_HI_RST;
      comms_value          <= 16'sh0000;
      tmo_cnt              <= 40'h0;
      tick_cnt             <= 32'h0;
      pv                   <= 16'sh0000;
      millivolt_reading    <= 16'sh0000;
      brk                  <= 1'b0;
      ctrl_out             <= 16'sh0000;
      alarm_beacon         <= 1'b0;
      alarm_relay          <= 1'b0;
      sensor_break         <= 1'b0;
      rdata                <= 32'h0;
    end else begin
      sensor_break_mode    <= next_mode;
      out_type             <= next_out_type;
      in_type              <= next_in_type;
      al_state             <= next_al_state;
      output_upper_limit   <= next_hi;
      output_lower_limit   <= next_lo;
      safe_value           <= next_safe;
      process_value_offset <= next_ofs;
      rate_filter_time     <= next_filt;
      mv_lo                <= next_mv_lo;
      mv_hi                <= next_mv_hi;
      comms_value          <= next_comms;
      tmo_cnt              <= next_tmo_cnt;
      tick_cnt             <= next_tick_cnt;
      pv                   <= next_pv;
      millivolt_reading    <= next_mvr;
      brk                  <= next_brk;
      ctrl_out             <= next_ctrl_out;
      alarm_beacon         <= next_beacon;
      alarm_relay          <= next_relay;
      sensor_break         <= brk;
      rdata                <= next_rdata;
    end
  end
endmodule : sbh_top

// ### tb/sbh_fe_model.sv
`timescale 1ns/1ps
module sbh_fe_model (
  input  wire logic               clk,          // clock
  input  wire logic               brk_cmd,      // open the sensor
  input  wire logic signed [15:0] mv_cmd,       // terminal level
  output logic                    open_circuit, // break flag, level
  output logic signed [15:0]      meas_value,   // linearised value
  output logic signed [15:0]      millivolt_in  // raw mV, hundredths
);
  initial begin
    open_circuit = 1'b0;
    meas_value = 16'sh0064;
    millivolt_in = 16'sh0000;
  end
  always @(posedge clk) begin
    open_circuit <= brk_cmd;
    millivolt_in <= mv_cmd;
    // an open sensor reads as a runaway value, not a frozen one
    meas_value <= brk_cmd ? 16'sh7FFF : 16'sh0064;
  end
endmodule : sbh_fe_model

// ### tb/sbh_properties.sv
`timescale 1ns/1ps
module sbh_checker (
  input wire logic               clk,          // clock
  input wire logic               rst_b,        // reset, active low
  input wire logic        [7:0]  addr,         // address
  input wire logic        [31:0] wdata,        // write data
  input wire logic               wr,           // write strobe
  input wire logic               rd,           // read strobe
  input wire logic        [31:0] rdata,        // read data
  input wire logic               open_circuit, // break flag
  input wire logic signed [15:0] ctrl_out,     // control output
  input wire logic               alarm_beacon, // beacon
  input wire logic               alarm_relay,  // relay
  input wire logic               sensor_break  // break in effect
);
  logic [1:0] mode_q;
  logic [1:0] next_mode_q;
  logic       ack_wr;
  logic       mode_wr;
  assign mode_wr = wr && addr == sbh_pkg::SBH_REG_SB_MODE;
  assign ack_wr  = wr && addr == sbh_pkg::SBH_REG_ACK && wdata[0];
  // shadow of the mode; code 3 is refused so it is skipped here too
  always_comb begin
    next_mode_q = mode_q;
    if (mode_wr && wdata[1:0] != 2'h3) next_mode_q = wdata[1:0];
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mode_q <= sbh_pkg::SBH_SB_ON;
    else mode_q <= next_mode_q;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  relay_follows_a: assert property (alarm_relay == alarm_beacon)
    else $error("relay and beacon differ");
  break_follow_a: assert property (open_circuit && mode_q != sbh_pkg::SBH_SB_OFF |-> ##2 sensor_break)
    else $error("break flag not taken");
  beacon_cause_a: assert property ($rose(alarm_beacon) |-> sensor_break)
    else $error("beacon raised without break");
  ack_ignored_a: assert property (open_circuit && $past(open_circuit) && alarm_beacon && ack_wr
    && mode_q != sbh_pkg::SBH_SB_OFF |=> alarm_beacon) else $error("ack cleared alarm in break");
  read_idle_a: assert property (!rd |=> rdata == 32'h0) else $error("read data outside slot");
  break_range_a: assert property (sensor_break |-> ctrl_out <= sbh_pkg::SBH_PCT_FULL
    && ctrl_out >= sbh_pkg::SBH_PCT_MFULL) else $error("break output beyond full scale");
  off_silent_a: assert property ((mode_q == sbh_pkg::SBH_SB_OFF) [*3] |-> !alarm_beacon)
    else $error("alarm in off mode");
  on_cancel_a: assert property ((mode_q == sbh_pkg::SBH_SB_ON && !sensor_break) [*3] |-> !alarm_beacon)
    else $error("alarm kept after clear");
  lat_hold_a: assert property (mode_q == sbh_pkg::SBH_SB_LAT && alarm_beacon && !ack_wr && !mode_wr
    |=> alarm_beacon) else $error("latched alarm dropped");
endmodule : sbh_checker
bind sbh_top sbh_checker i_sbh_checker (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .open_circuit,
  .ctrl_out, .alarm_beacon, .alarm_relay, .sensor_break);

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
  logic               clk, rst_b, wr, rd, brk_cmd, open_circuit;
  logic               alarm_beacon, alarm_relay, sensor_break;
  logic        [7:0]  addr;
  logic        [31:0] wdata, rdata;
  logic signed [15:0] mv_cmd, meas_value, millivolt_in, ctrl_out;
  int                 bad_count, samples_checked;
  sbh_top #(.COMMS_TMO_CYC(100), .TICK_CYC(10)) i_sbh_top (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
    .open_circuit, .meas_value, .millivolt_in, .ctrl_demand(16'sh0000), .ctrl_out, .alarm_beacon,
    .alarm_relay, .sensor_break);
  sbh_fe_model i_sbh_fe_model (.clk, .brk_cmd, .mv_cmd, .open_circuit, .meas_value, .millivolt_in);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata[15:0];
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd_reg(a, v);
    `CHK(v, e)
  endtask : rd_chk
  // with the filter off rate stands one tick only, so read it repeatedly across two ticks
  task automatic poll_rate(input logic [15:0] e);
    logic [15:0] v;
    int          n;
    n = 0;
    v = 16'h0000;
    while (v !== e && n < 12) begin
      rd_reg(sbh_pkg::SBH_REG_RATE, v);
      n++;
    end
    `CHK(v, e)
  endtask : poll_rate
  // bounded wait so a stuck break flag ends the run instead of hanging it
  task automatic wait_brk(input logic v);
    int n;
    n = 0;
    while (sensor_break !== v && n < 300) begin
      step(1);
      n++;
    end
    if (n == 300) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_brk
  task automatic set_brk(input logic v);
    @(posedge clk);
    brk_cmd <= v;
    wait_brk(v);
    step(2);
  endtask : set_brk
  task automatic t_reset();
    rd_chk(sbh_pkg::SBH_REG_SB_MODE, 16'h0001);
    rd_chk(sbh_pkg::SBH_REG_OUT_HI, 16'h03E8);
    rd_chk(sbh_pkg::SBH_REG_OUT_LO, 16'hFC18);
    rd_chk(sbh_pkg::SBH_REG_FILT, 16'h000F);
    rd_chk(8'h44, 16'h0000);
  endtask : t_reset
  task automatic t_on();
    wr_reg(sbh_pkg::SBH_REG_SAFE, 32'h0000012C);
    set_brk(1'b1);
    `CHK(ctrl_out, 16'sh012C)
    rd_chk(sbh_pkg::SBH_REG_PV, 16'h055C);
    `CHK(alarm_relay, 1'b1)
    wr_reg(sbh_pkg::SBH_REG_ACK, 32'h00000001);
    step(2);
    `CHK(alarm_beacon, 1'b1)
    set_brk(1'b0);
    `CHK(alarm_beacon, 1'b0)
  endtask : t_on
  task automatic t_lat();
    wr_reg(sbh_pkg::SBH_REG_SB_MODE, 32'h00000002);
    set_brk(1'b1);
    `CHK(ctrl_out, 16'sh012C)
    set_brk(1'b0);
    step(3);
    `CHK(alarm_beacon, 1'b1)
    wr_reg(sbh_pkg::SBH_REG_ACK, 32'h00000001);
    step(2);
    `CHK(alarm_beacon, 1'b0)
    wr_reg(sbh_pkg::SBH_REG_SB_MODE, 32'h00000003);
    rd_chk(sbh_pkg::SBH_REG_SB_MODE, 16'h0002);
    wr_reg(sbh_pkg::SBH_REG_SB_MODE, 32'h00000001);
  endtask : t_lat
  task automatic t_clip();
    wr_reg(sbh_pkg::SBH_REG_SAFE, 32'h00000000);
    wr_reg(sbh_pkg::SBH_REG_OUT_LO, 32'h0000000A);
    rd_chk(sbh_pkg::SBH_REG_SAFE, 16'h000A);
    wr_reg(sbh_pkg::SBH_REG_OUT_LO, 32'h0000FC18);
    wr_reg(sbh_pkg::SBH_REG_SAFE, 32'h00000032);
    wr_reg(sbh_pkg::SBH_REG_OUT_HI, 32'h00000028);
    rd_chk(sbh_pkg::SBH_REG_SAFE, 16'h0028);
    wr_reg(sbh_pkg::SBH_REG_OUT_HI, 32'h000003E8);
  endtask : t_clip
  task automatic t_off();
    wr_reg(sbh_pkg::SBH_REG_SB_MODE, 32'h00000000);
    set_brk(1'b1);
    `CHK(ctrl_out, 16'sh03E8)
    `CHK(alarm_beacon, 1'b0)
    wr_reg(sbh_pkg::SBH_REG_OUT_TYPE, 32'h00000002);
    step(3);
    `CHK(ctrl_out, 16'sh0000)
    rd_chk(sbh_pkg::SBH_REG_OUT_HI, 16'h0000);
    set_brk(1'b0);
    wr_reg(sbh_pkg::SBH_REG_OUT_TYPE, 32'h00000000);
    wr_reg(sbh_pkg::SBH_REG_OUT_HI, 32'h000003E8);
    wr_reg(sbh_pkg::SBH_REG_SB_MODE, 32'h00000001);
  endtask : t_off
  task automatic t_comms();
    wr_reg(sbh_pkg::SBH_REG_COMMS, 32'h00000005);
    wr_reg(sbh_pkg::SBH_REG_IN_TYPE, 32'h00000004);
    step(50);
    `CHK(sensor_break, 1'b0)
    wait_brk(1'b1);
    wr_reg(sbh_pkg::SBH_REG_COMMS, 32'h00000007);
    wait_brk(1'b0);
    wr_reg(sbh_pkg::SBH_REG_IN_TYPE, 32'h00000001);
  endtask : t_comms
  task automatic t_inputs();
    mv_cmd <= 16'sh04D2;
    step(3);
    rd_chk(sbh_pkg::SBH_REG_MV, 16'h04D2);
    wr_reg(sbh_pkg::SBH_REG_OFFSET, 32'h00000014);
    step(2);
    rd_chk(sbh_pkg::SBH_REG_PV, 16'h0078);
    wr_reg(sbh_pkg::SBH_REG_IN_TYPE, 32'h00000003);
    mv_cmd <= 16'sh2134;
    wait_brk(1'b1);
    mv_cmd <= 16'sh206C;
    wait_brk(1'b0);
    wr_reg(sbh_pkg::SBH_REG_IN_TYPE, 32'h00000001);
    wr_reg(sbh_pkg::SBH_REG_MV_HI, 32'h00002710);
    rd_chk(sbh_pkg::SBH_REG_MV_HI, 16'h1F40);
  endtask : t_inputs
  task automatic t_rate();
    wr_reg(sbh_pkg::SBH_REG_FILT, 32'h00000000);
    step(25);
    rd_chk(sbh_pkg::SBH_REG_RATE, 16'h0000);
    wr_reg(sbh_pkg::SBH_REG_OFFSET, 32'h000000AA);
    poll_rate(16'h0096);
    step(12);
    wr_reg(sbh_pkg::SBH_REG_FILT, 32'h0000000F);
    wr_reg(sbh_pkg::SBH_REG_OFFSET, 32'h00000140);
    poll_rate(16'h000A);
  endtask : t_rate
  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    brk_cmd = 1'b0;
    mv_cmd = 16'sh0000;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_on();
    t_lat();
    t_clip();
    t_off();
    t_comms();
    t_inputs();
    t_rate();
    tally_and_finish();
  end
endmodule : tb
